// *** pgw_pkg.sv ***
// Purpose: shared constants and carriers for the pin group writer / pulser
// Assumes: 10 MHz core clock, 32 output-capable pins
// Notes:   pulse widths arrive in microseconds (fractional milliseconds)
`default_nettype none
package pgw_pkg;

    // =====================================================================
    // sizes
    localparam int NUM_PINS   = 32;
    localparam int PIN_W      = 5;
    localparam int MAX_GROUPS = 4;
    localparam int CNT_W      = 6;
    localparam int NUM_SLOTS  = 5;
    localparam int WIDTH_W    = 20;
    localparam int TCNT_W     = 28;

    // =====================================================================
    // timing
    localparam int CLK_MHZ          = 10;
    localparam int CYC_PER_US       = CLK_MHZ;
    // shortest pulse scales inversely with clock: microseconds times MHz
    localparam int MIN_PULSE_US_MHZ = 200;
    localparam int MIN_PULSE_US     = (MIN_PULSE_US_MHZ + CLK_MHZ - 1)
                                      / CLK_MHZ;
    localparam logic [TCNT_W-1:0] MIN_PULSE_CYC =
        TCNT_W'(MIN_PULSE_US * CYC_PER_US);

    // =====================================================================
    // reset values
    localparam logic [NUM_PINS-1:0] OUT_RST = 32'h0000_0000;
    localparam logic [NUM_PINS-1:0] DIR_RST = 32'h0000_0000;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic [PIN_W-1:0] start;
        logic [CNT_W-1:0] count;
    } pgw_group_type;

    typedef struct packed {
        logic                           valid;
        logic [NUM_PINS-1:0]            value;
        pgw_group_type [MAX_GROUPS-1:0] groups;
    } pgw_grp_req_type;

    typedef struct packed {
        logic               valid;
        logic [PIN_W-1:0]   pin;
        logic [WIDTH_W-1:0] width_us;
    } pgw_pulse_req_type;

    typedef struct packed {
        logic             valid;
        logic [PIN_W-1:0] pin;
        logic             level;
    } pgw_pin_req_type;

endpackage : pgw_pkg
`default_nettype wire

// *** pgw_top.sv ***
// Purpose: simultaneous group writes and timed inverted pulses on out pins
// Assumes: requests come from same-clock firmware logic, one per kind/cycle
// Notes:   pins update one cycle after the internal level changes
//
// Summary of operation
// R1: start pin takes bit 0, upward after
// R2: further groups take next higher value bits
// R3: bad or non-output pin rejects whole write
// R4: all addressed pins change in one update
// R5: total width one pin up to all
// R6: width given in microseconds, fractional ms
// R7: minimum pulse width scales with core clock
// R8: pulse inverts the pin's present level
// R9: firmware configures pin as output first
// R10: short pulses timed to the exact cycle
// R11: long pulses equally timed, well within tolerance
// R12: five concurrent background pulses on distinct pins
// R13: new request replaces time; zero ends it
// R14: level written before config is held
// R15: pin returns to prior level after pulse
`timescale 1ns/1ps
`default_nettype none
module pgw_top
    import pgw_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              srst,
    // requests
    input  wire pgw_grp_req_type   grp_req,
    input  wire pgw_pulse_req_type pulse_req,
    input  wire pgw_pin_req_type   pin_req,
    input  wire pgw_pin_req_type   cfg_req,
    // answers
    output logic                   grp_done_q,
    output logic                   grp_err_q,
    output logic                   pulse_done_q,
    output logic                   pulse_err_q,
    // pins
    output logic [NUM_PINS-1:0]    pin_o_q,
    output logic [NUM_PINS-1:0]    pin_oe_q
);

    // =====================================================================
    // pin state
    logic [NUM_PINS-1:0] out_q;
    logic [NUM_PINS-1:0] out_d;
    logic [NUM_PINS-1:0] dir_q;
    logic [NUM_PINS-1:0] g_mask;
    logic [NUM_PINS-1:0] g_val;
    logic                g_err;
    logic [NUM_PINS-1:0] inv_c;

    // direction: level in out_q is untouched, so it becomes the initial
    // drive once the pin turns to output
    always_ff @(posedge clock) begin
        if (srst) begin
            dir_q <= DIR_RST;
        end else if (cfg_req.valid) begin
            dir_q[cfg_req.pin] <= cfg_req.level; // R14
        end
    end

    // =====================================================================
    // group decode
    always_comb begin
        int off;
        int pos;
        int bitx;
        off    = 0;
        pos    = 0;
        bitx   = 0;
        g_mask = '0;
        g_val  = '0;
        g_err  = 1'b0;
        for (int g = 0; g < MAX_GROUPS; g++) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (i < int'(grp_req.groups[g].count)) begin
                    pos  = int'(grp_req.groups[g].start) + i;
                    bitx = off + i; // R2
                    if (pos >= NUM_PINS || bitx >= NUM_PINS) begin
                        g_err = 1'b1; // R3 R5
                    end else begin
                        if (!dir_q[pos]) begin
                            g_err = 1'b1; // R3
                        end
                        g_mask[pos] = 1'b1;
                        g_val[pos]  = grp_req.value[bitx]; // R1
                    end
                end
            end
            off = off + int'(grp_req.groups[g].count);
        end
        // a single group longer than the pin count never reaches the
        // per-bit range test, so the total is checked here as well
        if (off > NUM_PINS) begin
            g_err = 1'b1; // R5
        end
    end

    always_comb begin
        out_d = out_q;
        if (pin_req.valid) begin
            out_d[pin_req.pin] = pin_req.level; // R14
        end
        if (grp_req.valid && !g_err) begin
            out_d = (out_d & ~g_mask) | (g_val & g_mask); // R4
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            out_q <= OUT_RST;
        end else begin
            out_q <= out_d;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            grp_done_q <= 1'b0;
            grp_err_q  <= 1'b0;
        end else begin
            grp_done_q <= grp_req.valid && !g_err;
            grp_err_q  <= grp_req.valid && g_err; // R3
        end
    end

    // =====================================================================
    // pulse slot selection
    logic              busy_q [NUM_SLOTS];
    logic [PIN_W-1:0]  spin_q [NUM_SLOTS];
    logic [TCNT_W-1:0] scnt_q [NUM_SLOTS];
    logic              p_ok;
    logic              p_found;
    logic              p_hit;
    int                p_sel;
    logic [TCNT_W-1:0] p_cyc;
    logic              p_zero;

    always_comb begin
        p_found = 1'b0;
        p_hit   = 1'b0;
        p_sel   = 0;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            if (busy_q[s] && spin_q[s] == pulse_req.pin && !p_hit) begin
                p_hit = 1'b1; // R13
                p_sel = s;
            end
        end
        if (!p_hit) begin
            for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
                if (!busy_q[s]) begin
                    p_found = 1'b1; // R12
                    p_sel   = s;
                end
            end
        end
        p_zero = (pulse_req.width_us == '0);
        p_cyc  = TCNT_W'(pulse_req.width_us) * TCNT_W'(CYC_PER_US); // R6
        if (p_cyc < MIN_PULSE_CYC) begin
            p_cyc = MIN_PULSE_CYC; // R7
        end
        p_ok = pulse_req.valid && dir_q[pulse_req.pin] // R9
               && (p_hit || p_found || p_zero);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pulse_done_q <= 1'b0;
            pulse_err_q  <= 1'b0;
        end else begin
            pulse_done_q <= p_ok;
            pulse_err_q  <= pulse_req.valid && !p_ok;
        end
    end

    // =====================================================================
    // pulse slots: every width counted to the cycle, short or long
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
        always_ff @(posedge clock) begin
            if (srst) begin
                busy_q[s] <= 1'b0;
                spin_q[s] <= '0;
                scnt_q[s] <= '0;
            end else if (p_ok && p_sel == s && (p_hit || !p_zero)) begin
                busy_q[s] <= !p_zero; // R13
                spin_q[s] <= pulse_req.pin;
                scnt_q[s] <= p_cyc; // R10 R11
            end else if (busy_q[s]) begin
                if (scnt_q[s] <= TCNT_W'(1)) begin
                    busy_q[s] <= 1'b0; // R15
                end else begin
                    scnt_q[s] <= scnt_q[s] - TCNT_W'(1); // R10 R11
                end
            end
        end

        slot_polarity_a: assert property (@(posedge clock) disable iff (srst)
            $rose(busy_q[s]) |=> // R8
            pin_o_q[spin_q[s]] == !$past(out_q[spin_q[s]]))
            else $error("pulse does not invert the pin level");

        slot_restore_a: assert property (@(posedge clock) disable iff (srst)
            $fell(busy_q[s]) |=> // R15
            pin_o_q[$past(spin_q[s])] == $past(out_q[spin_q[s]]))
            else $error("pin not restored after pulse");

        slot_count_a: assert property (@(posedge clock) disable iff (srst)
            busy_q[s] && scnt_q[s] > TCNT_W'(1) && !(p_ok && p_sel == s)
            |=> busy_q[s] && scnt_q[s] == $past(scnt_q[s]) - 1) // R10
            else $error("pulse counter did not advance");

        slot_min_a: assert property (@(posedge clock) disable iff (srst)
            busy_q[s] |-> scnt_q[s] <= $past(scnt_q[s]) // R7
            || scnt_q[s] >= MIN_PULSE_CYC)
            else $error("pulse shorter than minimum");

        for (genvar t = s + 1; t < NUM_SLOTS; t++) begin : g_pair
            slot_unique_a: assert property ( // R12
                @(posedge clock) disable iff (srst)
                busy_q[s] && busy_q[t] |-> spin_q[s] != spin_q[t])
                else $error("two slots pulse one pin");
        end
    end

    always_comb begin
        inv_c = '0;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            if (busy_q[s]) begin
                inv_c[spin_q[s]] = 1'b1; // R8
            end
        end
    end

    // =====================================================================
    // pin drive: one register for all pins keeps group updates atomic
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_o_q  <= OUT_RST;
            pin_oe_q <= DIR_RST;
        end else begin
            pin_o_q  <= out_q ^ inv_c; // R4 R8
            pin_oe_q <= dir_q;
        end
    end

    // =====================================================================
    // checks
    grp_reject_a: assert property (@(posedge clock) disable iff (srst)
        grp_req.valid && g_err && !pin_req.valid // R3
        |=> out_q == $past(out_q) && grp_err_q && !grp_done_q)
        else $error("rejected group write changed pins");

    grp_apply_a: assert property (@(posedge clock) disable iff (srst)
        grp_req.valid && !g_err && !pin_req.valid |=> grp_done_q // R1
        && out_q == (($past(out_q) & ~$past(g_mask))
                     | ($past(g_val) & $past(g_mask))))
        else $error("group write not applied in one update");

    grp_atomic_a: assert property (@(posedge clock) disable iff (srst)
        grp_done_q && !$past(pin_req.valid) && $past(inv_c) == '0
        && inv_c == '0 |=> pin_o_q == $past(out_q)) // R4
        else $error("group pins did not move together");

    zero_end_a: assert property (@(posedge clock) disable iff (srst)
        p_ok && p_hit && p_zero |=> !busy_q[$past(p_sel)]) // R13
        else $error("zero width did not end pulse");

    pulse_reject_a: assert property (@(posedge clock) disable iff (srst)
        pulse_req.valid && !dir_q[pulse_req.pin] // R9
        |=> pulse_err_q && !pulse_done_q)
        else $error("pulse on non-output pin accepted");

endmodule : pgw_top
`default_nettype wire

// *** pgw_top_bench.sv ***
// Purpose: self-checking bench for the pin group writer and pulser
// Assumes: answers one cycle after a request, pin levels one cycle later
// Notes:   pulse widths are checked to the exact cycle count, except the reloaded one, which is checked to within two cycles
`timescale 1ns/1ps
`default_nettype none
module pgw_top_bench;
    import pgw_pkg::*;

    typedef struct packed {
        logic [3:0]          ans;
        logic                chk;
        logic [NUM_PINS-1:0] pins;
    } pgw_note_type;
    typedef pgw_group_type [MAX_GROUPS-1:0] pgw_grps_type;

    // =====================================================================
    // signals
    logic                clock     = 1'b0;
    logic                srst      = 1'b1;
    pgw_grp_req_type     grp_req   = '0;
    pgw_pulse_req_type   pulse_req = '0;
    pgw_pin_req_type     pin_req   = '0;
    pgw_pin_req_type     cfg_req   = '0;
    logic                grp_done_q, grp_err_q, pulse_done_q, pulse_err_q;
    logic [NUM_PINS-1:0] pin_o_q, pin_oe_q, lvl, pin_exp;
    logic                pin_chk   = 1'b0;
    pgw_note_type        notes[$];
    pgw_note_type        nt;
    int                  error_cnt = 0;
    int                  n_tests   = 0;
    int                  seed      = 32'h5efc_d5b1;

    always #50 clock = ~clock;

    pgw_top pgw_top_i (
        .clock(clock), .srst(srst), .grp_req(grp_req),
        .pulse_req(pulse_req), .pin_req(pin_req), .cfg_req(cfg_req),
        .grp_done_q(grp_done_q), .grp_err_q(grp_err_q),
        .pulse_done_q(pulse_done_q), .pulse_err_q(pulse_err_q),
        .pin_o_q(pin_o_q), .pin_oe_q(pin_oe_q)
    );

    // =====================================================================
    // compare and report
    task automatic chk_pins(input string nm, input logic [NUM_PINS-1:0] e,
                            input logic [NUM_PINS-1:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pins

    task automatic chk_code(input string nm, input logic [3:0] e,
                            input logic [3:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_code

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // =====================================================================
    // monitor: oldest note per answer, group pins checked one cycle later
    always @(posedge clock) begin
        #1;
        if (pin_chk) begin
            pin_chk = 1'b0;
            chk_pins("group pins", pin_exp, pin_o_q);
        end
        if ({grp_done_q, grp_err_q, pulse_done_q, pulse_err_q} !== 4'h0) begin
            nt = '0;
            if (notes.size() > 0)
                nt = notes.pop_front();
            chk_code("answer", nt.ans,
                     {grp_done_q, grp_err_q, pulse_done_q, pulse_err_q});
            pin_chk = nt.chk;
            pin_exp = nt.pins;
        end
    end

    // =====================================================================
    // drivers: inputs change at the falling edge only
    function automatic pgw_grps_type mk(input int s0, c0, s1, c1);
        mk    = '0;
        mk[0] = '{s0[PIN_W-1:0], c0[CNT_W-1:0]};
        mk[1] = '{s1[PIN_W-1:0], c1[CNT_W-1:0]};
    endfunction : mk

    task automatic grp(input logic [31:0] v, input pgw_grps_type g,
                       input logic ok);
        int b;
        logic [NUM_PINS-1:0] e;
        b = 0;
        e = lvl;
        // later groups overwrite earlier ones where they overlap
        for (int k = 0; k < MAX_GROUPS; k++) begin
            for (int j = 0; j < int'(g[k].count); j++) begin
                e[(int'(g[k].start) + j) % NUM_PINS] = v[b % 32];
                b++;
            end
        end
        if (ok)
            lvl = e;
        @(negedge clock);
        grp_req = '{1'b1, v, g};
        notes.push_back('{ok ? 4'b1000 : 4'b0100, 1'b1, lvl});
        @(negedge clock);
        grp_req.valid = 1'b0;
    endtask : grp

    task automatic setp(input bit cfg, input int p, input logic l);
        @(negedge clock);
        if (cfg)
            cfg_req = '{1'b1, p[PIN_W-1:0], l};
        else
            pin_req = '{1'b1, p[PIN_W-1:0], l};
        @(negedge clock);
        cfg_req.valid = 1'b0;
        pin_req.valid = 1'b0;
    endtask : setp

    task automatic pulse(input int p, input int w, input logic [3:0] a);
        @(negedge clock);
        pulse_req = '{1'b1, p[PIN_W-1:0], w[WIDTH_W-1:0]};
        notes.push_back('{a, 1'b0, '0});
        @(negedge clock);
        pulse_req.valid = 1'b0;
    endtask : pulse

    // counts cycles the pin sits away from its resting level
    task automatic meas(input int p, output int n);
        n = 0;
        @(negedge clock);
        while (pin_o_q[p] !== lvl[p] && n < 40000) begin
            n++;
            @(negedge clock);
        end
    endtask : meas

    // =====================================================================
    // tests
    initial begin : main
        int n;
        lvl = '0;
        repeat (3) @(negedge clock);
        srst = 1'b0;
        chk_pins("enables after reset", '0, pin_oe_q);
        chk_pins("levels after reset", '0, pin_o_q);
        setp(1'b0, 20, 1'b1);
        lvl[20] = 1'b1;
        for (int p = 0; p < 31; p++)
            setp(1'b1, p, 1'b1);
        @(negedge clock);
        chk_pins("enables", 32'h7fff_ffff, pin_oe_q);
        chk_pins("held level", lvl, pin_o_q);
        $display("test reset and config done");
        grp(32'h0000_0083, mk(15, 4, 23, 4), 1'b1);
        repeat (6)
            grp($random(seed), mk($random(seed) & 15, ($random(seed) & 7) + 1,
                ($random(seed) & 15) + 8, ($random(seed) & 7) + 1), 1'b1);
        grp(32'h0000_00ff, mk(28, 4, 0, 0), 1'b0);
        setp(1'b1, 31, 1'b1);
        grp(32'h0000_00ff, mk(0, 2, 30, 4), 1'b0);
        grp($random(seed), mk(0, 32, 0, 0), 1'b1);
        grp(32'hffff_ffff, mk(0, 40, 0, 0), 1'b0);
        grp(32'h0000_0001, mk(9, 1, 0, 0), 1'b1);
        $display("test group writes done");
        pulse(5, 30, 4'b0010);
        meas(5, n);
        chk_pins("short pulse", 32'(300), 32'(n));
        pulse(6, 1, 4'b0010);
        meas(6, n);
        chk_pins("shortest pulse", 32'(200), 32'(n));
        pulse(7, 300, 4'b0010);
        meas(7, n);
        chk_pins("long pulse", 32'(3000), 32'(n));
        setp(1'b1, 31, 1'b0);
        pulse(31, 10, 4'b0001);
        $display("test single pulses done");
        for (int p = 0; p < NUM_SLOTS; p++)
            pulse(p, 2000, 4'b0010);
        pulse(8, 2000, 4'b0001);
        pulse(9, 0, 4'b0010);
        chk_pins("five running", lvl ^ 32'h0000_001f, pin_o_q);
        pulse(1, 0, 4'b0010);
        @(negedge clock);
        chk_pins("cancelled", 32'(lvl[1]), 32'(pin_o_q[1]));
        pulse(2, 25, 4'b0010);
        meas(2, n);
        chk_pins("reloaded", 32'(1), 32'(n >= 248 && n <= 252));
        repeat (20100) @(negedge clock);
        chk_pins("restored", lvl, pin_o_q);
        chk_pins("notes left", '0, 32'(notes.size()));
        $display("test background pulses done");
        final_report();
    end

    // the tests need some 25000 cycles; this span leaves ample room
    initial begin : watchdog
        repeat (60000) @(posedge clock);
        error_cnt++;
        final_report();
    end

endmodule : pgw_top_bench
`default_nettype wire
